// ### rtl/ram_block.sv
// one embedded synchronous ram block: sizes, modes, mixed widths, optional output registers
// assumes fabric user logic on ref_clk drives both ports; in_clr and out_clr are asynchronous
`timescale 1ns/1ns

// Contract
// - true dual-port only on medium and large
// - each port independently reads or writes
// - simultaneous read/write; collision gives old or fill
// - single port: written data shows on output
// - medium block hosts two half-size single ports
// - write and read ports may differ in width
// - every input captured in an input register
// - write strobe self-timed from port clock
// - output register optional, bypass skips a cycle
// - flow-through: read inputs on falling edge
// - largest size has no preload
// - input clear shows at read stage next edge, at a registered output one edge later
// - output clear changes output at once; only registered outputs clear, a bypassed a_q or b_q ignores out_clr
// - small block write registers share one clock
module ram_block #(
   parameter ram_block_pkg::size_t SIZE         = ram_block_pkg::SIZE_MEDIUM,
   parameter ram_block_pkg::mode_t MODE         = ram_block_pkg::MODE_TRUE_DUAL,
   parameter ram_block_pkg::rdw_t  RDW          = ram_block_pkg::RDW_OLD_DATA,
   parameter int                   A_WIDTH      = ram_block_pkg::DEFAULT_WIDTH,
   parameter int                   B_WIDTH      = ram_block_pkg::DEFAULT_WIDTH,
   parameter bit                   A_OUT_REG    = 1'b1,
   parameter bit                   B_OUT_REG    = 1'b1,
   parameter bit                   FLOW_THROUGH = 1'b0,
   parameter int                   BITS         = ram_block_pkg::capacity(SIZE),
   parameter int                   A_AW         = $clog2(BITS / A_WIDTH),
   parameter int                   B_AW         = $clog2(BITS / B_WIDTH)
) (
   input  wire logic               ref_clk,
   input  wire logic               reset,
   input  wire logic               in_clr,
   input  wire logic               out_clr,
   input  wire logic [A_AW-1:0]    a_addr,
   input  wire logic [A_WIDTH-1:0] a_data,
   input  wire logic               a_wr,
   input  wire logic               a_rd,
   output logic      [A_WIDTH-1:0] a_q,
   input  wire logic [B_AW-1:0]    b_addr,
   input  wire logic [B_WIDTH-1:0] b_data,
   input  wire logic               b_wr,
   input  wire logic               b_rd,
   output logic      [B_WIDTH-1:0] b_q
);

   // mode after size limits: small cannot do true dual, only medium splits in halves
   localparam ram_block_pkg::mode_t MODE_EFF =
      (SIZE == ram_block_pkg::SIZE_SMALL && MODE == ram_block_pkg::MODE_TRUE_DUAL) ?
         ram_block_pkg::MODE_SIMPLE_DUAL :
      (SIZE != ram_block_pkg::SIZE_MEDIUM && MODE == ram_block_pkg::MODE_DUAL_SINGLE) ?
         ram_block_pkg::MODE_SINGLE : MODE;
   localparam bit SPLIT = (MODE_EFF == ram_block_pkg::MODE_DUAL_SINGLE);
   localparam int SPAN  = SPLIT ? BITS / 2 : BITS;                  // per-memory capacity
   // flow-through only for simple dual on small and medium
   localparam bit FLOW  = FLOW_THROUGH && MODE_EFF == ram_block_pkg::MODE_SIMPLE_DUAL &&
                          SIZE != ram_block_pkg::SIZE_LARGE;

   logic               mem [0:BITS-1];      // storage, one bit per entry for mixed widths
   logic [A_AW-1:0]    a_addr_reg;          // input registers
   logic [A_WIDTH-1:0] a_data_reg;
   logic               a_wr_reg;
   logic               a_rd_reg;
   logic [B_AW-1:0]    b_addr_reg;
   logic [B_WIDTH-1:0] b_data_reg;
   logic               b_wr_reg;
   logic               b_rd_reg;
   logic               clr_seen_reg;        // input clear pending toward the outputs
   logic [A_WIDTH-1:0] a_qr_reg;            // array read stage
   logic [B_WIDTH-1:0] b_qr_reg;
   logic [A_WIDTH-1:0] a_qo_reg;            // optional output registers
   logic [B_WIDTH-1:0] b_qo_reg;
   logic [A_WIDTH-1:0] a_view;              // array contents at port a
   logic [B_WIDTH-1:0] b_view;
   int                 a_base;              // first bit of each port's word
   int                 b_base;
   logic               a_we, a_re, b_we, b_re, a_hit, b_hit;

   // bit address of a word; the upper memory of a split block sits in the top half
   function automatic int bit_base(input int addr, input int width, input bit upper);
      return ((addr * width) % SPAN) + (upper ? SPAN : 0);
   endfunction : bit_base

   // do two bit ranges share any bit
   function automatic bit overlap(input int b1, input int w1, input int b2, input int w2);
      return (b1 < b2 + w2) && (b2 < b1 + w1);
   endfunction : overlap

   assign a_base = bit_base(int'(a_addr_reg), A_WIDTH, 1'b0);
   assign b_base = bit_base(int'(b_addr_reg), B_WIDTH, SPLIT);

   // per-port actions; a write on a port wins over a read on the same port
   assign a_we  = a_wr_reg;
   assign a_re  = a_rd_reg && !a_we && MODE_EFF != ram_block_pkg::MODE_SIMPLE_DUAL;
   assign b_we  = b_wr_reg && (MODE_EFF == ram_block_pkg::MODE_TRUE_DUAL || SPLIT);
   assign b_re  = b_rd_reg && !b_we && MODE_EFF != ram_block_pkg::MODE_SINGLE;
   // a read landing on bits the other port writes this cycle
   assign a_hit = b_we && !SPLIT && overlap(a_base, A_WIDTH, b_base, B_WIDTH);
   assign b_hit = a_we && !SPLIT && overlap(b_base, B_WIDTH, a_base, A_WIDTH);

   // port a input registers and port b write registers, all on the rising edge
   always_ff @(posedge ref_clk or posedge in_clr) begin
      if (in_clr) begin
         a_addr_reg <= '0;
         a_data_reg <= '0;
         a_wr_reg   <= 1'b0;
         a_rd_reg   <= 1'b0;
         b_data_reg <= '0;
         b_wr_reg   <= 1'b0;
      end else if (reset) begin
         a_addr_reg <= '0;
         a_data_reg <= '0;
         a_wr_reg   <= 1'b0;
         a_rd_reg   <= 1'b0;
         b_data_reg <= '0;
         b_wr_reg   <= 1'b0;
      end else begin
         a_addr_reg <= a_addr;
         a_data_reg <= a_data;
         a_wr_reg   <= a_wr;
         a_rd_reg   <= a_rd;
         b_data_reg <= b_data;
         b_wr_reg   <= b_wr;
      end
   end

   // port b address and read enable: falling edge for flow-through, else rising
   generate
      if (FLOW) begin : g_b_fall
         // half a cycle earlier capture saves the read a full cycle
         always_ff @(negedge ref_clk or posedge in_clr) begin
            if (in_clr) begin
               b_addr_reg <= '0;
               b_rd_reg   <= 1'b0;
            end else if (reset) begin
               b_addr_reg <= '0;
               b_rd_reg   <= 1'b0;
            end else begin
               b_addr_reg <= b_addr;
               b_rd_reg   <= b_rd;
            end
         end
      end else begin : g_b_rise
         always_ff @(posedge ref_clk or posedge in_clr) begin
            if (in_clr) begin
               b_addr_reg <= '0;
               b_rd_reg   <= 1'b0;
            end else if (reset) begin
               b_addr_reg <= '0;
               b_rd_reg   <= 1'b0;
            end else begin
               b_addr_reg <= b_addr;
               b_rd_reg   <= b_rd;
            end
         end
      end
   endgenerate

   // preload: small and medium start at a known fill, the largest starts unknown
   generate
      if (SIZE != ram_block_pkg::SIZE_LARGE) begin : g_preload
         initial begin
            for (int i = 0; i < BITS; i++) mem[i] = ram_block_pkg::INIT_FILL;
         end
      end
   endgenerate

   // array write; the strobe is the registered request on the next edge, so user logic
   // never shapes a pulse. plain always because the preload also assigns the array.
   // two ports writing the same bit: port b lands last
   always @(posedge ref_clk) begin
      if (!reset && a_we) begin
         for (int i = 0; i < A_WIDTH; i++) mem[a_base + i] <= a_data_reg[i];
      end
      if (!reset && b_we) begin
         for (int i = 0; i < B_WIDTH; i++) mem[b_base + i] <= b_data_reg[i];
      end
   end

   // array contents under each registered address
   always_comb begin
      a_view = '0;
      b_view = '0;
      for (int i = 0; i < A_WIDTH; i++) a_view[i] = mem[a_base + i];
      for (int i = 0; i < B_WIDTH; i++) b_view[i] = mem[b_base + i];
   end

   // input clear reaches the read stage only at the next edge
   always_ff @(posedge ref_clk or posedge in_clr) begin
      if (in_clr) clr_seen_reg <= 1'b1;
      else        clr_seen_reg <= 1'b0;
   end

   // read stage, port a; single-port modes show the word just written
   always_ff @(posedge ref_clk) begin
      if (reset || clr_seen_reg) begin
         a_qr_reg <= '0;
      end else if (a_we && MODE_EFF != ram_block_pkg::MODE_TRUE_DUAL) begin
         a_qr_reg <= a_data_reg;
      end else if (a_re) begin
         // nonblocking write beside this read leaves the old word here
         if (a_hit && RDW == ram_block_pkg::RDW_DONT_CARE) a_qr_reg <= {A_WIDTH{ram_block_pkg::DONT_CARE_FILL}};
         else                                              a_qr_reg <= a_view;
      end
   end

   // read stage, port b
   always_ff @(posedge ref_clk) begin
      if (reset || clr_seen_reg) begin
         b_qr_reg <= '0;
      end else if (b_we && SPLIT) begin
         b_qr_reg <= b_data_reg;
      end else if (b_re) begin
         if (b_hit && RDW == ram_block_pkg::RDW_DONT_CARE) b_qr_reg <= {B_WIDTH{ram_block_pkg::DONT_CARE_FILL}};
         else                                              b_qr_reg <= b_view;
      end
   end

   // output registers, cleared at once by out_clr
   always_ff @(posedge ref_clk or posedge out_clr) begin
      if (out_clr) begin
         a_qo_reg <= '0;
         b_qo_reg <= '0;
      end else if (reset) begin
         a_qo_reg <= '0;
         b_qo_reg <= '0;
      end else begin
         a_qo_reg <= a_qr_reg;
         b_qo_reg <= b_qr_reg;
      end
   end

   // pick the output stage per port at build time; bypass trades fmax for a cycle
   generate
      if (A_OUT_REG) begin : g_a_reg
         assign a_q = a_qo_reg;
      end else begin : g_a_byp
         assign a_q = a_qr_reg;
      end
      if (B_OUT_REG && !FLOW) begin : g_b_reg
         assign b_q = b_qo_reg;
      end else begin : g_b_byp
         assign b_q = b_qr_reg;
      end
   endgenerate

   // checks
   a_b_no_write: assert property (@(posedge ref_clk) disable iff (reset)
      (MODE_EFF == ram_block_pkg::MODE_SIMPLE_DUAL || MODE_EFF == ram_block_pkg::MODE_SINGLE) |-> !b_we)
      else $error("port b wrote in a mode without a port b writer");
   a_in_capture: assert property (@(posedge ref_clk) disable iff (reset || in_clr)
      1'b1 |=> (a_wr_reg == $past(a_wr) && a_addr_reg == $past(a_addr)))
      else $error("port a inputs not captured on the edge");
   a_write_through: assert property (@(posedge ref_clk) disable iff (reset || in_clr)
      (a_we && MODE_EFF == ram_block_pkg::MODE_SINGLE) |=> a_qr_reg == $past(a_data_reg))
      else $error("single port write data missing from output");
   a_b_read_data: assert property (@(posedge ref_clk) disable iff (reset || in_clr)
      (b_re && !b_hit) |=> b_qr_reg == $past(b_view))
      else $error("port b read returned wrong word");
   a_rdw_fill: assert property (@(posedge ref_clk) disable iff (reset || in_clr)
      (b_re && b_hit && RDW == ram_block_pkg::RDW_DONT_CARE) |=> &b_qr_reg)
      else $error("colliding read did not return the fill");
   a_out_pipe: assert property (@(posedge ref_clk) disable iff (reset || out_clr)
      1'b1 |=> a_qo_reg == $past(a_qr_reg))
      else $error("output register lost a cycle");
   a_out_clear: assert property (@(posedge ref_clk) out_clr |-> (a_qo_reg == '0 && b_qo_reg == '0))
      else $error("output clear not seen at once");
   a_in_clear: assert property (@(posedge ref_clk) disable iff (reset)
      (in_clr && !$past(in_clr)) |=> (a_qr_reg == '0 && b_qr_reg == '0))
      else $error("input clear did not reach read stage next edge");
   a_split_half: assert property (@(posedge ref_clk) disable iff (reset)
      (SPLIT && (b_we || b_re)) |-> (b_base >= SPAN && a_base < SPAN))
      else $error("split memories crossed halves");
   a_write_lands: assert property (@(posedge ref_clk) disable iff (reset || in_clr)
      (a_we && !b_we && MODE_EFF == ram_block_pkg::MODE_SIMPLE_DUAL) ##1 (a_addr_reg == $past(a_addr_reg))
         |-> a_view == $past(a_data_reg))
      else $error("write not in array one edge after request");

endmodule : ram_block

// ### rtl/ram_block_pkg.sv
// shared types and constants for the embedded ram block model
// assumes one fabric clock; consumers write ram_block_pkg::name, nothing is imported
package ram_block_pkg;

   // block size, one-hot codes
   typedef enum logic [2:0] {
      SIZE_SMALL  = 3'h1,  // small_ram_block
      SIZE_MEDIUM = 3'h2,  // medium_ram_block
      SIZE_LARGE  = 3'h4   // largest block, no preload
   } size_t;

   // operating mode, one-hot codes
   typedef enum logic [3:0] {
      MODE_TRUE_DUAL   = 4'h1,  // two read/write ports
      MODE_SIMPLE_DUAL = 4'h2,  // port a writes, port b reads
      MODE_SINGLE      = 4'h4,  // port a only
      MODE_DUAL_SINGLE = 4'h8   // two single-port memories, one half each
   } mode_t;

   // read-during-write answer when a read hits bits being written
   typedef enum logic [1:0] {
      RDW_OLD_DATA  = 2'h1,  // previous contents
      RDW_DONT_CARE = 2'h2   // fill pattern stands for undefined bits
   } rdw_t;

   // capacities in bits, parity bits included
   localparam int SMALL_BITS  = 576;
   localparam int MEDIUM_BITS = 4608;
   localparam int LARGE_BITS  = 589824;

   // default port width, divides every capacity
   localparam int DEFAULT_WIDTH = 18;

   // value driven in place of undefined read bits
   localparam logic DONT_CARE_FILL = 1'b1;
   // preload value of small and medium arrays
   localparam logic INIT_FILL = 1'b0;
   // reset and clear value of every data register bit
   localparam logic DATA_RESET = 1'b0;

   // capacity of one block size
   function automatic int capacity(input size_t s);
      case (s)
         SIZE_SMALL:  return SMALL_BITS;
         SIZE_LARGE:  return LARGE_BITS;
         default:     return MEDIUM_BITS;
      endcase
   endfunction : capacity

endpackage : ram_block_pkg

// ### sim/fabric_user.sv
// fabric-side user logic for both ports of the ram block: random and directed traffic
// assumes the bench seeds $urandom, makes ref_clk and toggles en by non-blocking assignment
`timescale 1ns/1ns
module fabric_user #(
   parameter int BITS = 4608,
   parameter int AW   = 1,
   parameter int BW   = 16,
   parameter int A_AW = 13,
   parameter int B_AW = 9
) (
   input  wire logic            ref_clk,
   input  wire logic            en,
   output logic     [A_AW-1:0]  a_addr,
   output logic     [AW-1:0]    a_data,
   output logic                 a_wr,
   output logic                 a_rd,
   output logic     [B_AW-1:0]  b_addr,
   output logic     [BW-1:0]    b_data,
   output logic                 b_wr,
   output logic                 b_rd
);
   int unsigned op_a;  // 0 idle, 1 write, 2 read
   int unsigned op_b;  // same coding for port b

   // one directed cycle; a_data takes the low bits of db
   task automatic put(input bit wa, input bit ra, input int aa, input bit wb, input bit rb,
                      input int ab, input logic [BW-1:0] db);
      @(negedge ref_clk);
      {a_wr, a_rd, b_wr, b_rd} <= {wa, ra, wb, rb};  // plain levels, no strobe shaping
      a_addr <= A_AW'(aa);
      b_addr <= B_AW'(ab);
      a_data <= AW'(db);
      b_data <= db;
   endtask : put

   // random traffic, crowded at both ends of the array so the ports overlap often
   initial begin
      {a_addr, a_data, a_wr, a_rd, b_addr, b_data, b_wr, b_rd} = '0;
      forever begin
         @(negedge ref_clk);
         if (en) begin
            op_a = $urandom_range(2);
            op_b = $urandom_range(2);
            // one access per port per cycle
            {a_wr, a_rd, b_wr, b_rd} <= {op_a == 1, op_a == 2, op_b == 1, op_b == 2};
            a_addr <= A_AW'($urandom_range(1) ? $urandom_range(63) : BITS / AW - 64 + $urandom_range(63));
            b_addr <= B_AW'($urandom_range(1) ? $urandom_range(3) : BITS / BW - 4 + $urandom_range(3));
            a_data <= AW'($urandom);
            b_data <= BW'($urandom);
         end
      end
   end
endmodule : fabric_user

// ### sim/testbench.sv
// self-checking bench: medium block, true dual port, x1 port a unregistered, x16 port b registered
// assumes one ref_clk domain; a bit-level reference array predicts every read stage and output
`timescale 1ns/1ns
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
   localparam int BITS = ram_block_pkg::MEDIUM_BITS;
   localparam int AW   = 1;                    // port a width
   localparam int BW   = 16;                   // port b width
   localparam int A_AW = $clog2(BITS / AW);
   localparam int B_AW = $clog2(BITS / BW);

   logic            ref_clk;
   logic            reset;
   logic            in_clr;
   logic            out_clr;
   logic            en;                        // random traffic on
   logic [A_AW-1:0] a_addr;
   logic [AW-1:0]   a_data;
   logic            a_wr;
   logic            a_rd;
   logic [AW-1:0]   a_q;
   logic [B_AW-1:0] b_addr;
   logic [BW-1:0]   b_data;
   logic            b_wr;
   logic            b_rd;
   logic [BW-1:0]   b_q;
   int              mismatches;
   int              check_count;
   int              cycles;
   bit              cmp_on;                    // compares start after first reset
   bit              mem [BITS];                // reference array, preload zeros
   logic [AW-1:0]   exp_a;                     // port a read stage drives a_q
   logic [BW-1:0]   exp_brs;                   // port b read stage
   logic [BW-1:0]   exp_b;                     // port b output register
   bit              pa_wr, pa_rd, pb_wr, pb_rd;  // requests held in input registers
   int              pa_addr, pb_addr;
   logic [AW-1:0]   pa_data;
   logic [BW-1:0]   pb_data;

   ram_block #(
      .SIZE         (ram_block_pkg::SIZE_MEDIUM),
      .MODE         (ram_block_pkg::MODE_TRUE_DUAL),
      .RDW          (ram_block_pkg::RDW_OLD_DATA),
      .A_WIDTH      (AW),
      .B_WIDTH      (BW),
      .A_OUT_REG    (1'h0),
      .B_OUT_REG    (1'h1),
      .FLOW_THROUGH (1'h0)
   ) DUT (.ref_clk(ref_clk), .reset(reset), .in_clr(in_clr), .out_clr(out_clr),
      .a_addr(a_addr), .a_data(a_data), .a_wr(a_wr), .a_rd(a_rd), .a_q(a_q),
      .b_addr(b_addr), .b_data(b_data), .b_wr(b_wr), .b_rd(b_rd), .b_q(b_q));

   fabric_user #(.BITS(BITS), .AW(AW), .BW(BW), .A_AW(A_AW), .B_AW(B_AW)) fab (
      .ref_clk(ref_clk), .en(en), .a_addr(a_addr), .a_data(a_data), .a_wr(a_wr), .a_rd(a_rd),
      .b_addr(b_addr), .b_data(b_data), .b_wr(b_wr), .b_rd(b_rd));

   // verdict and end of run
   task results;
      if (mismatches == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results

   // 20 MHz clock
   initial begin
      ref_clk = 1'h0;
      forever #25 ref_clk = ~ref_clk;
   end

   // reference model: reads see the array before the same cycle's writes, port b wins a tie
   always @(posedge ref_clk) begin
      if (reset) begin
         exp_a = '0;
         exp_brs = '0;
         exp_b = '0;
      end else begin
         exp_b = out_clr ? '0 : exp_brs;  // output reg one edge behind read stage
         if (in_clr) begin
            exp_a = '0;
            exp_brs = '0;
         end else begin
            for (int i = 0; i < AW; i++) if (pa_rd && !pa_wr) exp_a[i] = mem[pa_addr * AW + i];
            for (int i = 0; i < BW; i++) if (pb_rd && !pb_wr) exp_brs[i] = mem[pb_addr * BW + i];
            for (int i = 0; i < AW; i++) if (pa_wr) mem[pa_addr * AW + i] = pa_data[i];
            for (int i = 0; i < BW; i++) if (pb_wr) mem[pb_addr * BW + i] = pb_data[i];
         end
      end
      // capture this edge's requests; reset and input clear empty them
      {pa_wr, pa_rd, pb_wr, pb_rd} = (reset || in_clr) ? 4'h0 : {a_wr, a_rd, b_wr, b_rd};
      pa_addr = int'(a_addr);
      pb_addr = int'(b_addr);
      pa_data = a_data;
      pb_data = b_data;
   end

   // compare every cycle once outputs have settled
   always @(negedge ref_clk) begin
      if (cmp_on) begin
         #2;
         `CHECK(a_q, exp_a)
         if (out_clr) begin
            `CHECK(b_q, {BW{1'h0}})
         end else begin
            `CHECK(b_q, exp_b)
         end
      end
   end

   // hang guard, well above the ~935 cycles the run needs
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         results();
      end
   end

   initial begin
      void'($urandom(32'hF2EF225B));
      reset = 1'h1;
      in_clr = 1'h0;
      out_clr = 1'h0;
      en = 1'h0;
      repeat (4) @(posedge ref_clk);
      cmp_on = 1'h1;
      @(negedge ref_clk);
      reset = 1'h0;
      en <= 1'h1;
      repeat (600) @(negedge ref_clk);
      en <= 1'h0;
      // fill word 0, read bit 4 back across widths, then a refused write+read beside a collision
      fab.put(0, 0, 0, 1, 0, 0, {BW{1'h1}});
      fab.put(0, 1, 4, 0, 0, 0, '0);
      fab.put(1, 1, 3, 0, 1, 0, '0);
      fab.put(0, 0, 0, 0, 1, 0, '0);
      fab.put(0, 0, 0, 0, 0, 0, '0);
      repeat (3) @(negedge ref_clk);
      // input clear: a_q holds until the edge, b_q one edge later
      in_clr = 1'h1;
      @(negedge ref_clk);
      in_clr = 1'h0;
      repeat (2) @(negedge ref_clk);
      fab.put(0, 1, 4, 0, 1, 0, '0);
      fab.put(0, 0, 0, 0, 0, 0, '0);
      repeat (3) @(negedge ref_clk);
      // output clear acts at once and holds while high
      out_clr = 1'h1;
      repeat (2) @(negedge ref_clk);
      out_clr = 1'h0;
      repeat (2) @(negedge ref_clk);
      // second reset mid-run keeps the array
      reset = 1'h1;
      repeat (2) @(negedge ref_clk);
      reset = 1'h0;
      en <= 1'h1;
      repeat (300) @(negedge ref_clk);
      en <= 1'h0;
      // read-only use: contents written earlier, every write request held low from here on
      fab.put(0, 1, 4, 0, 1, 0, '0);
      fab.put(0, 1, 3, 0, 1, 287, '0);
      fab.put(0, 0, 0, 0, 0, 0, '0);
      repeat (4) @(negedge ref_clk);
      results();
   end
endmodule : testbench
